// >>> hw/sfan_core.sv
// short operand float add-normalize datapath and its microsequence
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`include "sfan_defines.svh"
module sfan_core
	import sfan_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire sfan_float_t first_op_in,
	input wire sfan_float_t second_op_in,
	input wire logic [3:0] target_operand_field_in,
	input wire logic underflow_mask_in,
	input wire logic significance_mask_in,
	output logic [3:0] microbranch_address_out,
	output logic store_we_out,
	output logic [3:0] store_addr_out,
	output sfan_float_t store_data_out,
	output logic [1:0] condition_code_out,
	output sfan_irq_t irq_req_out,
	output logic end_op_out,
	output logic busy_out
);
	sfan_state_t state_q;
	logic sign1_q, sign2_q;
	logic [`SFAN_EXP_W-1:0] ssum_q;
	logic [`SFAN_EXP_W-1:0] exp_q;
	logic [`SFAN_WIDE_W-1:0] fpa_q, fpb_q;
	logic [3:0] br_q;
	logic [3:0] target_q;
	logic zero_q, sub_q, swap_q;

	// short-operand range test on a difference
	function automatic logic in_range(input logic carry, input logic [7:0] d);
		in_range = carry ? (d[7:3] == 5'h0_0) : (d[7:3] == 5'h1_f);
	endfunction : in_range

	// widen a 24-bit fraction: top digit overflow room, low digit guard
	function automatic logic [31:0] widen(input logic [23:0] f);
		widen = {4'h0, f, 4'h0};
	endfunction : widen

	logic [8:0] diff_w;
	logic carry_w;
	logic [3:0] br_w;
	assign diff_w = {1'b0, 1'b0, second_op_in.exp} + {1'b0, 1'b1, ~first_op_in.exp} + 9'h0_01;
	assign carry_w = diff_w[8];
	always_comb begin
		br_w[`SFAN_BR_CARRY] = carry_w;
		br_w[`SFAN_BR_SIGN] = first_op_in.sign == second_op_in.sign;
		br_w[`SFAN_BR_RANGE] = in_range(carry_w, diff_w[7:0]);
		br_w[`SFAN_BR_ZERO] = diff_w[7:0] == `SFAN_EXP_ZERO;
	end

	logic [`SFAN_WIDE_W-1:0] sum_w;
	assign sum_w = sub_q ? fpa_q + (~fpb_q + 32'h0000_0001) : fpa_q + fpb_q;
	logic hi_zero_w;
	assign hi_zero_w = fpa_q[`SFAN_WIDE_W-5:`SFAN_HI_DIG_LO] == 4'h0;

	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			state_q <= SFAN_IDLE;
			sign1_q <= 1'b0;
			sign2_q <= 1'b0;
			ssum_q <= `SFAN_EXP_ZERO;
			exp_q <= `SFAN_EXP_ZERO;
			fpa_q <= 32'h0000_0000;
			fpb_q <= 32'h0000_0000;
			br_q <= 4'h0;
			target_q <= 4'h0;
			zero_q <= 1'b0;
			sub_q <= 1'b0;
			swap_q <= 1'b0;
			microbranch_address_out <= 4'h0;
			store_we_out <= 1'b0;
			store_addr_out <= 4'h0;
			store_data_out <= '0;
			condition_code_out <= `SFAN_COND_ZERO;
			irq_req_out <= '0;
			end_op_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			store_we_out <= 1'b0;
			end_op_out <= 1'b0;
			irq_req_out <= '0;
			case (state_q)
			SFAN_IDLE: begin
				if (start_in) begin
					sign1_q <= first_op_in.sign;
					sign2_q <= second_op_in.sign;
					ssum_q <= diff_w[7:0];
					br_q <= br_w;
					microbranch_address_out <= br_w;
					target_q <= target_operand_field_in;
					sub_q <= !br_w[`SFAN_BR_SIGN];
					busy_out <= 1'b1;
					zero_q <= 1'b0;
					// result exponent is the larger one, bit 7 clear
					exp_q <= carry_w ? {1'b0, second_op_in.exp} : {1'b0, first_op_in.exp};
					if (!br_w[`SFAN_BR_RANGE]) begin
						// out of range: larger operand alone becomes the result
						fpa_q <= carry_w ? widen(second_op_in.frac) : widen(first_op_in.frac);
						sign2_q <= carry_w ? second_op_in.sign : first_op_in.sign;
						// no subtraction happens, so the larger operand's sign must survive
						sub_q <= 1'b0;
						swap_q <= 1'b0;
						state_q <= SFAN_FOVF;
					end else begin
						fpa_q <= widen(first_op_in.frac);
						fpb_q <= widen(second_op_in.frac);
						swap_q <= 1'b0;
						state_q <= br_w[`SFAN_BR_ZERO] ? SFAN_ADD : SFAN_EQUAL;
					end
				end
			end
			SFAN_EQUAL: begin
				// shift the smaller-exponent fraction, step difference toward zero
				if (br_q[`SFAN_BR_CARRY]) begin
					fpa_q <= fpa_q >> `SFAN_DIGIT;
					ssum_q <= ssum_q - `SFAN_EXP_ONE;
				end else begin
					fpb_q <= fpb_q >> `SFAN_DIGIT;
					ssum_q <= ssum_q + `SFAN_EXP_ONE;
				end
				// branch looks one cycle ahead of the shift count
				if ((br_q[`SFAN_BR_CARRY] && ssum_q[3:0] == 4'h1)
					|| (!br_q[`SFAN_BR_CARRY] && ssum_q[3:0] == 4'hf)) begin
					state_q <= SFAN_ADD;
				end
			end
			SFAN_ADD: begin
				fpa_q <= sum_w;
				fpb_q <= sum_w;
				zero_q <= sum_w == 32'h0000_0000;
				state_q <= (sub_q && sum_w[`SFAN_WIDE_W-1]) ? SFAN_RECOMP : SFAN_FOVF;
			end
			SFAN_RECOMP: begin
				// take magnitude; sign flips relative to the first operand
				fpa_q <= ~fpa_q + 32'h0000_0001;
				fpb_q <= ~fpa_q + 32'h0000_0001;
				sign1_q <= !sign1_q;
				// normalization entered when the leading digit pattern is insignificant
				state_q <= ((fpa_q[31:27] == 5'h1_f) && (fpa_q[30:0] != 31'h0000_0000)) ?
					SFAN_NORM : SFAN_FOVF;
			end
			SFAN_FOVF: begin
				if (fpa_q[`SFAN_OVF_BIT]) begin
					fpa_q <= fpa_q >> `SFAN_DIGIT;
					exp_q <= exp_q + `SFAN_EXP_ONE;
					state_q <= SFAN_STORE;
				end else if (zero_q || fpa_q == 32'h0000_0000) begin
					state_q <= SFAN_STORE;
				end else begin
					state_q <= hi_zero_w ? SFAN_NORM : SFAN_STORE;
				end
				if (sub_q) begin
					sign2_q <= sign1_q;
				end
			end
			SFAN_NORM: begin
				fpb_q <= fpa_q;
				if (fpa_q[27:24] == 4'h0 && fpa_q[23:0] != 24'h00_0000 &&
					(fpa_q << `SFAN_DIGIT) == 32'h0000_0000) begin
					state_q <= SFAN_STORE;
				end else if (hi_zero_w && fpa_q != 32'h0000_0000) begin
					fpa_q <= fpa_q << `SFAN_DIGIT;
					exp_q <= exp_q - `SFAN_EXP_ONE;
				end else begin
					state_q <= SFAN_STORE;
				end
			end
			SFAN_STORE: begin
				store_we_out <= 1'b1;
				store_addr_out <= target_q;
				state_q <= SFAN_ENDOP;
				if (fpa_q == 32'h0000_0000) begin
					condition_code_out <= `SFAN_COND_ZERO;
					irq_req_out.significance <= significance_mask_in;
					store_data_out <= significance_mask_in ?
						{1'b0, exp_q[6:0], 24'h00_0000} : '0;
				end else if (exp_q[7]) begin
					// carry bit dropped on store, exponent off by 128
					if (!exp_q[6] || underflow_mask_in) begin
						store_data_out <= {sign2_q, exp_q[6:0], fpa_q[27:4]};
						condition_code_out <= sign2_q ? `SFAN_COND_NEG : `SFAN_COND_POS;
					end else begin
						store_data_out <= '0;
						condition_code_out <= `SFAN_COND_ZERO;
					end
					irq_req_out.overflow <= !exp_q[6];
					irq_req_out.underflow <= exp_q[6] && underflow_mask_in;
				end else begin
					store_data_out <= {sign2_q, exp_q[6:0], fpa_q[27:4]};
					condition_code_out <= sign2_q ? `SFAN_COND_NEG : `SFAN_COND_POS;
				end
			end
			SFAN_ENDOP: begin
				end_op_out <= 1'b1;
				busy_out <= 1'b0;
				state_q <= SFAN_IDLE;
			end
			default: begin
				state_q <= SFAN_IDLE;
			end
			endcase
		end
	end

	branch_carry_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_IDLE && start_in |=> microbranch_address_out[3] == $past(carry_w))
		else $error("branch carry bit wrong");
	branch_sign_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_IDLE && start_in |=>
		microbranch_address_out[2] == $past(first_op_in.sign == second_op_in.sign))
		else $error("branch sign bit wrong");
	branch_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_IDLE && start_in && br_w[0] |-> br_w[3])
		else $error("zero difference without carry");
	end_after_store_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		store_we_out |=> end_op_out)
		else $error("no end op after store");
	end_single_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		end_op_out |=> !end_op_out)
		else $error("end op longer than one cycle");
	zero_cc_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		store_we_out && store_data_out[23:0] == 24'h00_0000 |-> condition_code_out == 2'h0)
		else $error("zero result with nonzero code");
	ovf_irq_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_STORE && fpa_q != 32'h0000_0000 && exp_q[7] && !exp_q[6]
		|=> irq_req_out.overflow)
		else $error("overflow not interrupted");
	norm_exp_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_NORM && $past(state_q) == SFAN_NORM && fpa_q != $past(fpa_q)
		|-> exp_q == $past(exp_q) - 8'h01)
		else $error("normalize shift without exponent decrement");
	run_length_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_IDLE && start_in |-> ##[2:40] end_op_out)
		else $error("execution did not end");
	add_path_c: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_ADD && !sub_q);
	recomp_c: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
		state_q == SFAN_RECOMP);
	ovf_c: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) irq_req_out.overflow);
	sig_c: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) irq_req_out.significance);
endmodule : sfan_core

// >>> hw/sfan_defines.svh
// constants for the short float add-normalize datapath
`ifndef SFAN_DEFINES_SVH
`define SFAN_DEFINES_SVH
`define SFAN_EXP_W 8
`define SFAN_FRAC_W 24
`define SFAN_WIDE_W 32
`define SFAN_DIGIT 4
`define SFAN_GUARD_LO 4
`define SFAN_OVF_BIT 28
`define SFAN_HI_DIG_LO 24
`define SFAN_EXP_ONE 8'h01
`define SFAN_EXP_ZERO 8'h00
`define SFAN_BR_CARRY 3
`define SFAN_BR_SIGN 2
`define SFAN_BR_RANGE 1
`define SFAN_BR_ZERO 0
`define SFAN_COND_ZERO 2'h0
`define SFAN_COND_NEG 2'h1
`define SFAN_COND_POS 2'h2
`endif

// >>> hw/sfan_pkg.sv
// types shared by the short float add-normalize datapath
package sfan_pkg;
	typedef struct packed {
		logic sign;
		logic [6:0] exp;
		logic [23:0] frac;
	} sfan_float_t;
	typedef struct packed {
		logic overflow;
		logic underflow;
		logic significance;
	} sfan_irq_t;
	typedef enum logic [2:0] {
		SFAN_IDLE = 3'b000,
		SFAN_EQUAL = 3'b001,
		SFAN_ADD = 3'b010,
		SFAN_RECOMP = 3'b011,
		SFAN_FOVF = 3'b100,
		SFAN_NORM = 3'b101,
		SFAN_STORE = 3'b110,
		SFAN_ENDOP = 3'b111
	} sfan_state_t;
endpackage : sfan_pkg

// >>> sim/sfan_store_model.sv
// local float register store that receives the core's result writes
`timescale 1ns/1ps
module sfan_store_model
	import sfan_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic store_we_in,
	input wire logic [3:0] store_addr_in,
	input wire sfan_float_t store_data_in,
	input wire logic [3:0] rd_addr_in,
	output sfan_float_t rd_data_out
);
	sfan_float_t regs_q [16];
	always_ff @(posedge sys_clk_in) begin
		if (store_we_in) begin
			regs_q[store_addr_in] <= store_data_in;
		end
	end
	assign rd_data_out = regs_q[rd_addr_in];
endmodule : sfan_store_model

// >>> sim/short_float_add_normalize_tb.sv
// self-checking bench for the short float add-normalize core
`timescale 1ns/1ps
module short_float_add_normalize_tb
	import sfan_pkg::*;
;
	logic sys_clk_in, rstn_in, start_in, underflow_mask_in, significance_mask_in;
	sfan_float_t first_op_in, second_op_in, store_data_out, rd_data;
	logic [3:0] target_operand_field_in, microbranch_address_out, store_addr_out, rd_sel;
	logic store_we_out, end_op_out, busy_out;
	logic [1:0] condition_code_out;
	sfan_irq_t irq_req_out;
	int failures, comparisons, tests;
	logic [31:0] seed_q, ra, rb;
	logic [31:0] corner_a [9] = '{32'h4110_0000, 32'h4110_0000, 32'h4810_0000, 32'h4910_0000,
		32'h4010_0000, 32'h4010_0000, 32'h7FF0_0000, 32'h0010_0000, 32'h4110_0000};
	logic [31:0] corner_b [9] = '{32'h4110_0000, 32'hC110_0000, 32'h4010_0000, 32'h4010_0000,
		32'h4710_0000, 32'h4810_0000, 32'h7FF0_0000, 32'h8008_0000, 32'hC120_0000};
	sfan_core u_sfan_core (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .start_in(start_in),
		.first_op_in(first_op_in), .second_op_in(second_op_in),
		.target_operand_field_in(target_operand_field_in),
		.underflow_mask_in(underflow_mask_in), .significance_mask_in(significance_mask_in),
		.microbranch_address_out(microbranch_address_out), .store_we_out(store_we_out),
		.store_addr_out(store_addr_out), .store_data_out(store_data_out),
		.condition_code_out(condition_code_out), .irq_req_out(irq_req_out),
		.end_op_out(end_op_out), .busy_out(busy_out));
	sfan_store_model u_sfan_store_model (.sys_clk_in(sys_clk_in), .store_we_in(store_we_out),
		.store_addr_in(store_addr_out), .store_data_in(store_data_out), .rd_addr_in(rd_sel),
		.rd_data_out(rd_data));
	function automatic logic [31:0] next_rand(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : next_rand
	// returns {irq, condition code, stored word}; smaller fraction loses digits past the guard
	function automatic logic [36:0] expect_fn(logic [31:0] a, logic [31:0] b, logic um, logic sm);
		int d, e;
		logic [31:0] l, s, r, t;
		logic sg;
		d = int'(b[30:24]) - int'(a[30:24]);
		l = (d >= 0) ? b : a;
		s = (d >= 0) ? a : b;
		e = int'(l[30:24]);
		sg = l[31];
		r = {4'h0, l[23:0], 4'h0};
		t = {4'h0, s[23:0], 4'h0} >> (4 * ((d < 0) ? -d : d));
		if (a[31] == b[31]) r = r + t;
		else if (r >= t) r = r - t;
		else begin
			r = t - r;
			sg = s[31];
		end
		if (r == 0) return {2'b00, sm, 2'h0, 1'b0, sm ? e[6:0] : 7'h00, 24'h00_0000};
		if (r[31:28] != 0) begin
			r = r >> 4;
			e++;
		end
		while (r[27:24] == 0) begin
			r = r << 4;
			e--;
		end
		if (e < 0 && !um) return 37'h0;
		return {e > 127, e < 0, 1'b0, sg ? 2'h1 : 2'h2, sg, e[6:0], r[27:4]};
	endfunction : expect_fn
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic run_op(input logic [31:0] a, input logic [31:0] b, input logic um,
		input logic sm, input logic [3:0] tgt);
		logic [36:0] ev;
		int d, n;
		ev = expect_fn(a, b, um, sm);
		d = int'(b[30:24]) - int'(a[30:24]);
		@(posedge sys_clk_in);
		start_in <= 1'b1;
		first_op_in <= a;
		second_op_in <= b;
		underflow_mask_in <= um;
		significance_mask_in <= sm;
		target_operand_field_in <= tgt;
		rd_sel <= tgt;
		// start held a second cycle with new operands: must be ignored while busy
		@(posedge sys_clk_in);
		first_op_in <= ~a;
		#1;
		check(32'(busy_out), 32'h0000_0001);
		@(posedge sys_clk_in);
		start_in <= 1'b0;
		#1;
		n = 0;
		while (store_we_out !== 1'b1 && n < 40) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		check(32'(store_we_out), 32'h0000_0001);
		check(32'(microbranch_address_out), 32'({d >= 0, a[31] == b[31], d >= -8 && d <= 7,
			d == 0}));
		check(store_data_out, ev[31:0]);
		check(32'(store_addr_out), 32'(tgt));
		check(32'(condition_code_out), 32'(ev[33:32]));
		check(32'(irq_req_out), 32'(ev[36:34]));
		@(posedge sys_clk_in);
		#1;
		check(32'({end_op_out, busy_out}), 32'h0000_0002);
		check(rd_data, ev[31:0]);
		tests++;
		$display("test %0d done at %0t", tests, $time);
	endtask : run_op
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// roughly 220 operations of under 45 cycles each
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		failures++;
		finish_test();
	end
	initial begin
		rstn_in = 1'b0;
		start_in = 1'b0;
		first_op_in = '0;
		second_op_in = '0;
		underflow_mask_in = 1'b0;
		significance_mask_in = 1'b0;
		target_operand_field_in = 4'h0;
		rd_sel = 4'h0;
		failures = 0;
		comparisons = 0;
		tests = 0;
		seed_q = 32'h0000_0036;
		repeat (8) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		#1;
		check(32'({store_we_out, end_op_out, busy_out}), 32'h0000_0000);
		for (int i = 0; i < 18; i++) begin
			run_op(corner_a[i % 9], corner_b[i % 9], i >= 9, i >= 9, 4'(i));
		end
		for (int i = 0; i < 200; i++) begin
			seed_q = next_rand(seed_q);
			ra = seed_q;
			seed_q = next_rand(seed_q);
			// second exponent kept near the first so most pairs fall in range
			rb = {seed_q[31], ra[30:24] + {{3{seed_q[27]}}, seed_q[27:24]}, seed_q[23:0]};
			run_op(ra, rb, seed_q[0], seed_q[1], seed_q[7:4]);
		end
		finish_test();
	end
endmodule : short_float_add_normalize_tb
